// file: hw/bit_axil.sv
`default_nettype none
// AXI4-Lite slave front end: takes address and data in either order
module bit_axil
  import bit_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             WR_EN,
  output logic [11:0]      WR_ADDR,
  output logic [31:0]      WR_DATA,
  output logic [3:0]       WR_STRB,
  input  wire logic        WR_OK,
  output logic             RD_EN,
  output logic [11:0]      RD_ADDR,
  input  wire bit_rsp_t    RD_RSP
);
  typedef struct packed {
    logic        aw_have;
    logic        w_have;
    logic [11:0] aw;
    logic [31:0] w;
    logic [3:0]  strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bit_axi_state_t;
  bit_axi_state_t s_q, s_d;

  assign S_AXI_AWREADY = !s_q.aw_have && !s_q.bvalid;
  assign S_AXI_WREADY  = !s_q.w_have && !s_q.bvalid;
  assign S_AXI_ARREADY = !s_q.rvalid;
  assign S_AXI_BVALID  = s_q.bvalid;
  assign S_AXI_BRESP   = s_q.bresp;
  assign S_AXI_RVALID  = s_q.rvalid;
  assign S_AXI_RDATA   = s_q.rdata;
  assign S_AXI_RRESP   = s_q.rresp;
  assign WR_EN   = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign WR_ADDR = s_q.aw;
  assign WR_DATA = s_q.w;
  assign WR_STRB = s_q.strb;
  assign RD_EN   = S_AXI_ARVALID && S_AXI_ARREADY;
  assign RD_ADDR = S_AXI_ARADDR;

  // Channel bookkeeping
  always_comb begin
    s_d = s_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      s_d.aw_have = 1'b1;
      s_d.aw      = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      s_d.w_have = 1'b1;
      s_d.w      = S_AXI_WDATA;
      s_d.strb   = S_AXI_WSTRB;
    end
    if (WR_EN) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = WR_OK ? 2'h0 : 2'h2;
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (RD_RSP.valid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = RD_RSP.data;
      s_d.rresp  = RD_RSP.resp;
    end else if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// file: hw/bit_pkg.sv
`default_nettype none
package bit_pkg;
  // Control register image
  typedef struct packed {
    logic       flag;
    logic [2:0] clk_sel;
    logic       clr;
    logic [2:0] int_sel;
  } bit_ctrl_t;
  // Stabilisation sequencer states
  typedef enum logic [1:0] {
    BIT_ST_WAIT = 2'b01,
    BIT_ST_RUN  = 2'b10
  } bit_state_t;
  // AXI read answer
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic [1:0]  resp;
  } bit_rsp_t;
endpackage
`default_nettype wire

// file: hw/bit_prescaler.sv
`default_nettype none
`include "bit_regs.svh"
// Divider held while RUN is low and zeroed by RESTART; one tick per 2^(sel+4) clocks
module bit_prescaler
  import bit_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  input  wire logic       RUN,
  input  wire logic       RESTART,
  input  wire logic [2:0] SEL,
  output logic            TICK
);
  typedef struct packed {
    logic [`BIT_PRE_WIDTH-1:0] cnt;
  } bit_pre_state_t;
  bit_pre_state_t s_q, s_d;
  logic [`BIT_PRE_WIDTH-1:0] mask;

  // Mask of low bits that must be all ones
  always_comb begin
    // Shift count kept four bits wide so selects 4..7 do not wrap
    mask = ~(11'h7ff << ({1'b0, SEL} + 4'(`BIT_PRE_BASE)));
    s_d  = s_q;
    if (RESTART) begin
      s_d.cnt = '0;
    end else if (RUN) begin
      s_d.cnt = s_q.cnt + 11'h001;
    end
  end

  assign TICK = RUN && !RESTART && ((s_q.cnt & mask) == mask);

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// file: hw/bit_regs.svh
`ifndef BIT_REGS_SVH
`define BIT_REGS_SVH
// Register byte addresses (printed offsets are not multiples of four: index * 4)
`define BIT_IDX_CTRL      8'h8b
`define BIT_IDX_COUNT     8'h8c
`define BIT_IDX_IRQ_STAT  8'h90
`define BIT_IDX_IRQ_MASK  8'h91
`define BIT_IDX_STAB      8'h92
`define BIT_ADDR_CTRL     12'h22c
`define BIT_ADDR_COUNT    12'h230
`define BIT_ADDR_IRQ_STAT 12'h240
`define BIT_ADDR_IRQ_MASK 12'h244
`define BIT_ADDR_STAB     12'h248
// Control register fields
`define BIT_FLAG_POS      7
`define BIT_CLR_POS       3
`define BIT_CTRL_RESET    8'h77
`define BIT_COUNT_RESET   8'h00
// Prescaler: select n divides by 2^(n+4)
`define BIT_PRE_BASE      4
`define BIT_PRE_WIDTH     11
// Stabilisation wait in interval events
`define BIT_STAB_EVENTS   8'h01
`endif

// file: hw/bit_timer.sv
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none
`include "bit_regs.svh"
module bit_timer
  import bit_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        STOP_MODE,
  input  wire logic        STOP_WAKE,
  output logic             WDT_TICK,
  output logic             INTERVAL_IRQ_PULSE,
  output logic             STABLE,
  output logic             IRQ
);
  typedef struct packed {
    bit_ctrl_t  ctrl;
    logic [7:0] count;
    logic       match;
    logic       pulse;
    logic       irq_stat;
    logic       irq_mask;
    logic       enable;
    bit_state_t state;
    logic [7:0] stab_cnt;
    logic [2:0] stop_sync;
    logic       stop;
    logic       wake_prev;
  } bit_state_s_t;
  bit_state_s_t s_q, s_d;

  logic        tick;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_en;
  logic [11:0] rd_addr;
  bit_rsp_t    rd_rsp;
  logic        wake_now;
  logic        new_match;
  logic        run;

  // Match test: low bits p..0 all ones
  function automatic logic match_of(input logic [7:0] cnt, input logic [2:0] p);
    logic [7:0] m;
    m = ~(8'hfe << p);
    return (cnt & m) == m;
  endfunction

  // Known register address test
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == `BIT_ADDR_CTRL) || (a == `BIT_ADDR_COUNT) || (a == `BIT_ADDR_IRQ_STAT)
        || (a == `BIT_ADDR_IRQ_MASK) || (a == `BIT_ADDR_STAB);
  endfunction

  bit_axil u_axil (
    .CLK_SYS       (CLK_SYS),
    .RESET         (RESET),
    .S_AXI_AWADDR  (S_AXI_AWADDR),
    .S_AXI_AWVALID (S_AXI_AWVALID),
    .S_AXI_AWREADY (S_AXI_AWREADY),
    .S_AXI_WDATA   (S_AXI_WDATA),
    .S_AXI_WSTRB   (S_AXI_WSTRB),
    .S_AXI_WVALID  (S_AXI_WVALID),
    .S_AXI_WREADY  (S_AXI_WREADY),
    .S_AXI_BRESP   (S_AXI_BRESP),
    .S_AXI_BVALID  (S_AXI_BVALID),
    .S_AXI_BREADY  (S_AXI_BREADY),
    .S_AXI_ARADDR  (S_AXI_ARADDR),
    .S_AXI_ARVALID (S_AXI_ARVALID),
    .S_AXI_ARREADY (S_AXI_ARREADY),
    .S_AXI_RDATA   (S_AXI_RDATA),
    .S_AXI_RRESP   (S_AXI_RRESP),
    .S_AXI_RVALID  (S_AXI_RVALID),
    .S_AXI_RREADY  (S_AXI_RREADY),
    .WR_EN         (wr_en),
    .WR_ADDR       (wr_addr),
    .WR_DATA       (wr_data),
    .WR_STRB       (wr_strb),
    .WR_OK         (wr_ok),
    .RD_EN         (rd_en),
    .RD_ADDR       (rd_addr),
    .RD_RSP        (rd_rsp)
  );

  // Counter stops while STOP is held; clear restarts the prescaler too
  assign run = !s_q.stop;

  bit_prescaler u_pre (
    .CLK_SYS (CLK_SYS),
    .RESET   (RESET),
    .RUN     (run),
    .RESTART (s_q.ctrl.clr),
    .SEL     (s_q.ctrl.clk_sel),
    .TICK    (tick)
  );

  assign wr_ok     = is_mapped(wr_addr);
  assign wake_now  = STOP_WAKE && !s_q.wake_prev;
  assign new_match = match_of(s_q.count, s_q.ctrl.int_sel) && !s_q.match;

  // Read mux
  always_comb begin
    rd_rsp       = '0;
    rd_rsp.valid = rd_en;
    case (rd_addr)
      `BIT_ADDR_CTRL:     rd_rsp.data = {24'h000000, s_q.ctrl};
      `BIT_ADDR_COUNT:    rd_rsp.data = {24'h000000, s_q.count};
      `BIT_ADDR_IRQ_STAT: rd_rsp.data = {31'h00000000, s_q.irq_stat};
      `BIT_ADDR_IRQ_MASK: rd_rsp.data = {31'h00000000, s_q.irq_mask};
      `BIT_ADDR_STAB:     rd_rsp.data = {31'h00000000, s_q.state == BIT_ST_RUN};
      default:            rd_rsp.resp = 2'h2;
    endcase
  end

  // Next-state logic
  always_comb begin
    s_d       = s_q;
    s_d.pulse = 1'b0;
    // STOP pin sync: three stages, change accepted when last two agree
    s_d.stop_sync = {s_q.stop_sync[1:0], STOP_MODE};
    if (s_q.stop_sync[2] == s_q.stop_sync[1]) begin
      s_d.stop = s_q.stop_sync[2];
    end
    s_d.wake_prev = STOP_WAKE;
    // Clear bit lives one cycle only
    s_d.ctrl.clr = 1'b0;
    if (s_q.ctrl.clr) begin
      s_d.count = 8'h00;
      s_d.match = 1'b0;
    end else if (tick) begin
      s_d.count = s_q.count + 8'h01;
      s_d.match = match_of(s_q.count, s_q.ctrl.int_sel);
      if (new_match) begin
        s_d.pulse = 1'b1;
      end
    end
    // Stabilisation wait counts interval events
    case (s_q.state)
      BIT_ST_WAIT: begin
        if (s_q.pulse) begin
          s_d.stab_cnt = s_q.stab_cnt + 8'h01;
          if (s_q.stab_cnt + 8'h01 >= `BIT_STAB_EVENTS) begin
            s_d.state = BIT_ST_RUN;
          end
        end
      end
      BIT_ST_RUN: begin
      end
      default: s_d.state = BIT_ST_WAIT;
    endcase
    // Wake-up from STOP restarts the wait and wins over a same-cycle event
    if (wake_now) begin
      s_d.state    = BIT_ST_WAIT;
      s_d.stab_cnt = 8'h00;
      s_d.count    = 8'h00;
    end
    // Register writes
    if (wr_en && wr_addr == `BIT_ADDR_CTRL && wr_strb[0]) begin
      s_d.ctrl.clk_sel = wr_data[6:4];
      s_d.ctrl.int_sel = wr_data[2:0];
      s_d.ctrl.clr     = wr_data[`BIT_CLR_POS];
      if (!wr_data[`BIT_FLAG_POS]) begin
        s_d.ctrl.flag = 1'b0;
      end
    end
    if (wr_en && wr_addr == `BIT_ADDR_IRQ_STAT && wr_strb[0] && wr_data[0]) begin
      s_d.irq_stat = 1'b0;
    end
    if (wr_en && wr_addr == `BIT_ADDR_IRQ_MASK && wr_strb[0]) begin
      s_d.irq_mask = wr_data[0];
    end
    // Event set wins over same-cycle clear
    if (s_q.pulse) begin
      s_d.ctrl.flag = 1'b1;
      s_d.irq_stat  = 1'b1;
    end
  end

  assign WDT_TICK           = s_q.pulse;
  assign INTERVAL_IRQ_PULSE = s_q.pulse && s_q.irq_mask;
  assign STABLE             = (s_q.state == BIT_ST_RUN);
  assign IRQ                = s_q.irq_stat && s_q.irq_mask;

  // State register; reset starts stabilisation at divide-by-2048
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_q       <= '0;
      s_q.ctrl  <= `BIT_CTRL_RESET;
      s_q.count <= `BIT_COUNT_RESET;
      s_q.state <= BIT_ST_WAIT;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// file: tb/bit_timer_asserts.sv
`default_nettype none
module bit_timer_asserts (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        STOP_MODE,
  input wire logic        STOP_WAKE,
  input wire logic        WDT_TICK,
  input wire logic        INTERVAL_IRQ_PULSE,
  input wire logic        STABLE,
  input wire logic        IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  logic [4:0] gap_q;
  // Cycles since the last interval event, saturating
  always_ff @(posedge CLK_SYS) begin
    if (RESET) gap_q <= 5'h1f;
    else if (WDT_TICK) gap_q <= 5'h00;
    else if (gap_q != 5'h1f) gap_q <= gap_q + 5'h01;
  end
  sequence s_wake;
    $rose(STOP_WAKE);
  endsequence
  sequence s_stopped;
    STOP_MODE [*6];
  endsequence
  a_tick_single: assert property (WDT_TICK |=> !WDT_TICK)
    else $error("interval event longer than one cycle");
  a_irq_gated: assert property (INTERVAL_IRQ_PULSE |-> WDT_TICK)
    else $error("interrupt pulse without interval event");
  a_irq_follows: assert property (INTERVAL_IRQ_PULSE |-> ##[1:2] IRQ)
    else $error("enabled event did not raise the interrupt");
  a_stop_halts: assert property (s_stopped |-> !WDT_TICK)
    else $error("interval event while stopped");
  a_tick_spacing: assert property (WDT_TICK |-> gap_q >= 5'h0f)
    else $error("interval events too close");
  a_wake_restab: assert property (s_wake |-> ##[1:3] !STABLE)
    else $error("wake did not restart stabilisation");
  a_resp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> $stable(S_AXI_RDATA))
    else $error("read data changed while held");
endmodule

bind bit_timer bit_timer_asserts bit_timer_asserts_inst (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .STOP_MODE(STOP_MODE), .STOP_WAKE(STOP_WAKE),
  .WDT_TICK(WDT_TICK), .INTERVAL_IRQ_PULSE(INTERVAL_IRQ_PULSE), .STABLE(STABLE), .IRQ(IRQ));
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
`include "bit_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, awv, wv, bry, arv, rry, stop, wake;
  logic        awr, wrr, bv, arr, rv, tick, pls, stab, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0]  ws;
  logic [1:0]  br, rr;
  int          mismatches, tests_run, cyc, gap, ticks, seed, n, p, s;
  logic [33:0] rq[$];
  logic [31:0] mq[$];
  logic [1:0]  bq[$];
  int          pq[$];

  bit_timer bit_timer_inst (
    .CLK_SYS(clk), .RESET(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .STOP_MODE(stop), .STOP_WAKE(wake),
    .WDT_TICK(tick), .INTERVAL_IRQ_PULSE(pls), .STABLE(stab), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write: address and data offered together, response taken late on purpose
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw;
    bq.push_back(r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta || awr;
      tw = tw || wrr;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    do @(negedge clk); while (!bv);
    @(posedge clk) bry <= 1'b1;
    @(posedge clk) bry <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, input logic [33:0] e, input logic [31:0] m);
    rq.push_back(e & {2'b11, m});
    mq.push_back(m);
    ara <= a;
    arv <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk) arv <= 1'b0;
    do @(negedge clk); while (!rv);
    @(posedge clk) rry <= 1'b1;
    @(posedge clk) rry <= 1'b0;
  endtask

  task automatic wait_tick();
    do @(negedge clk); while (!tick);
    @(posedge clk);
  endtask

  // Scoreboard and event timer; also cuts a hang short
  always @(negedge clk) begin
    if (rv && rry) chk("rdata", rq.pop_front(), {rr, rdat & mq.pop_front()});
    if (bv && bry) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, br});
    if (tick) begin
      if (pq.size() > 0) chk("period", 34'(pq.pop_front()), 34'(gap));
      gap = 0;
      ticks++;
    end
    gap++;
    cyc++;
    if (cyc > 60000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    {rst, awv, wv, bry, arv, rry, stop, wake} = 8'h80;
    {awa, ara, wd, ws} = {56'h0, 4'hf};
    {seed, mismatches, tests_run, cyc, gap, ticks} = {32'd9544, 160'd0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`BIT_ADDR_CTRL, 34'h77, 32'hff);
    rd_reg(`BIT_ADDR_COUNT, 34'h0, 32'hff);
    rd_reg(`BIT_ADDR_STAB, 34'h0, 32'h1);
    rd_reg(12'h100, 34'h2_0000_0000, 32'h0);
    // Default divide-by-2048: one count step after 2048 clocks, the next at 4096
    repeat (2100) @(posedge clk);
    rd_reg(`BIT_ADDR_COUNT, 34'h1, 32'hff);
    wr_reg(`BIT_ADDR_IRQ_MASK, 32'h0, 2'b00);
    wr_reg(12'h100, 32'h0, 2'b10);
    $display("test reset values done");
    for (n = 0; n < 5; n++) begin
      p = (n == 0) ? 7 : (n == 1) ? 0 : $random(seed) & 7;
      s = (n == 1) ? 7 : ($random(seed) & 7) % (8 - p);
      wr_reg(`BIT_ADDR_CTRL, 32'(s * 16 + 8 + p), 2'b00);
      wait_tick();
      pq.push_back(1 << (s + p + 5));
      while (pq.size() > 0) @(posedge clk);
    end
    rd_reg(`BIT_ADDR_STAB, 34'h1, 32'h1);
    $display("test periods done");
    wr_reg(`BIT_ADDR_CTRL, 32'h08, 2'b00);
    rd_reg(`BIT_ADDR_COUNT, 34'h0, 32'hff);
    rd_reg(`BIT_ADDR_CTRL, 34'h0, 32'h7f);
    wait_tick();
    wr_reg(`BIT_ADDR_CTRL, 32'hff, 2'b00);
    rd_reg(`BIT_ADDR_CTRL, 34'hf7, 32'hff);
    wr_reg(`BIT_ADDR_CTRL, 32'h77, 2'b00);
    rd_reg(`BIT_ADDR_CTRL, 34'h77, 32'hff);
    rd_reg(`BIT_ADDR_IRQ_STAT, 34'h1, 32'h1);
    chk("irq masked", 34'h0, {33'h0, irq});
    $display("test clear and flag done");
    wr_reg(`BIT_ADDR_IRQ_MASK, 32'h1, 2'b00);
    repeat (3) @(posedge clk);
    chk("irq enabled", 34'h1, {33'h0, irq});
    wr_reg(`BIT_ADDR_CTRL, 32'h08, 2'b00);
    do @(negedge clk); while (!pls);
    @(posedge clk);
    wr_reg(`BIT_ADDR_CTRL, 32'h7f, 2'b00);
    wr_reg(`BIT_ADDR_IRQ_STAT, 32'h1, 2'b00);
    repeat (3) @(posedge clk);
    chk("irq cleared", 34'h0, {33'h0, irq});
    rd_reg(`BIT_ADDR_IRQ_STAT, 34'h0, 32'h1);
    $display("test interrupt done");
    wr_reg(`BIT_ADDR_CTRL, 32'h08, 2'b00);
    stop <= 1'b1;
    repeat (5) @(posedge clk);
    n = ticks;
    repeat (200) @(posedge clk);
    chk("stop ticks", 34'(n), 34'(ticks));
    stop <= 1'b0;
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    chk("stable after wake", 34'h0, {33'h0, stab});
    wake <= 1'b0;
    wait_tick();
    repeat (3) @(posedge clk);
    rd_reg(`BIT_ADDR_STAB, 34'h1, 32'h1);
    $display("test stop and wake done");
    give_verdict();
  end
endmodule
`default_nettype wire
